// >>> design/wot_cfg.svh
// register map, field positions, reset values and count settings of the one-shot timer
`ifndef WOT_CFG_SVH
`define WOT_CFG_SVH

`define WOT_CNT_W        8
`define WOT_ADDR_W       12

`define WOT_OFF_MODE     12'h000
`define WOT_OFF_OUTCTL   12'h004
`define WOT_OFF_TRIG     12'h008
`define WOT_OFF_SRC      12'h00C
`define WOT_OFF_PRESC    12'h010
`define WOT_OFF_PRIM     12'h014
`define WOT_OFF_SEC      12'h018
`define WOT_OFF_STATUS   12'h01C

`define WOT_IDX_MODE     3'h0
`define WOT_IDX_OUTCTL   3'h1
`define WOT_IDX_TRIG     3'h2
`define WOT_IDX_SRC      3'h3
`define WOT_IDX_PRESC    3'h4
`define WOT_IDX_PRIM     3'h5
`define WOT_IDX_SEC      3'h6
`define WOT_IDX_STATUS   3'h7

`define WOT_MODE_RUN     0
`define WOT_MODE_OPM_LO  4
`define WOT_MODE_OPM_HI  5
`define WOT_OUT_ONESHOT  0
`define WOT_OUT_LEVEL    1
`define WOT_TRIG_PINEN   0
`define WOT_TRIG_POL     1
`define WOT_TRIG_EXTEN   2
`define WOT_TRIG_BOTH    3

`define WOT_RST_RELOAD   8'hFF
`define WOT_RST_PULSE    1'b1
`define WOT_RST_OPMODE   2'h3

`define WOT_SRC_F1       2'h0
`define WOT_SRC_F2       2'h1
`define WOT_SRC_F8       2'h2
`define WOT_SRC_NEIGH    2'h3
`define WOT_DIV_LAST     3'h7

`endif

// >>> design/wot_count_source.sv
// count-source selector: divided system clock or neighbour underflow as a one-cycle enable
`timescale 1ns/10ps
`default_nettype none
`include "wot_cfg.svh"
module wot_count_source (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] srcSel,
    input  wire logic       neighbourUnderflow,
    output var  logic       tick
);
    import wot_pkg::*;

    wot_div_s div_ff;
    wot_div_s nxt_div;

    always_comb begin
        nxt_div = div_ff;
        nxt_div.cnt = div_ff.cnt + 3'h1;
        unique case (srcSel)
            `WOT_SRC_F1:    nxt_div.tick = 1'b1;
            `WOT_SRC_F2:    nxt_div.tick = div_ff.cnt[0];
            `WOT_SRC_F8:    nxt_div.tick = (div_ff.cnt == `WOT_DIV_LAST);
            `WOT_SRC_NEIGH: nxt_div.tick = neighbourUnderflow;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign tick = div_ff.tick;
endmodule
`default_nettype wire

// >>> design/wot_pin_sync.sv
// trigger pin synchroniser and active-edge detector
`timescale 1ns/10ps
`default_nettype none
module wot_pin_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pinIn,
    input  wire logic polarity,
    input  wire logic bothEdge,
    output var  logic edgeSeen
);
    import wot_pkg::*;

    wot_sync_s sy_ff;
    wot_sync_s nxt_sy;

    always_comb begin
        nxt_sy = sy_ff;
        nxt_sy.meta = pinIn;
        nxt_sy.sync = sy_ff.meta;
        nxt_sy.prev = sy_ff.sync;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sy_ff <= '0;
        end else begin
            sy_ff <= nxt_sy;
        end
    end

    // polarity 0 picks rising, 1 falling; ignored when both edges are chosen
    always_comb begin
        if (bothEdge) begin
            edgeSeen = sy_ff.sync ^ sy_ff.prev;
        end else if (polarity) begin
            edgeSeen = !sy_ff.sync && sy_ff.prev;
        end else begin
            edgeSeen = sy_ff.sync && !sy_ff.prev;
        end
    end
endmodule
`default_nettype wire

// >>> design/wot_pkg.sv
// types shared by the one-shot timer modules
`include "wot_cfg.svh"
package wot_pkg;
    typedef enum logic [1:0] {
        WOT_PH_IDLE  = 2'b00,
        WOT_PH_WAIT  = 2'b01,
        WOT_PH_PULSE = 2'b10
    } wot_phase_e;

    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`WOT_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
    } wot_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } wot_apb_rsp_s;

    typedef struct packed {
        wot_phase_e            phase;
        logic                  runReq;
        logic                  runAct;
        logic                  oneShot;
        logic                  levelSel;
        logic                  pinTrigEn;
        logic                  trigPol;
        logic                  extInEn;
        logic                  bothEdge;
        logic [1:0]            srcSel;
        logic [1:0]            opMode;
        logic [`WOT_CNT_W-1:0] preRel;
        logic [`WOT_CNT_W-1:0] primRel;
        logic [`WOT_CNT_W-1:0] secRel;
        logic [`WOT_CNT_W-1:0] secStage;
        logic [`WOT_CNT_W-1:0] preCnt;
        logic [`WOT_CNT_W-1:0] tmrCnt;
        logic                  pulseOut;
        logic                  timerIrq;
        logic                  extIrq;
        wot_apb_rsp_s          rsp;
    } wot_state_s;

    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } wot_div_s;

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } wot_sync_s;
endpackage

// >>> design/wot_timer.sv
// wait one-shot pulse timer with apb register slave
//
// Contract
// - wait underflow loads secondary, keeps counting
// - pulse underflow reloads primary, clears one-shot bit
// - every stop reloads counters before halting
// - phase lengths are (pre+1)(reload+1) ticks
// - busy pin trigger ignored, pin interrupt still raised
// - stop on end, run clear, one-shot clear
// - timer interrupt with end of pulse
// - trigger enable off leaves pin plain interrupt
// - primary and prescaler reads return counters
// - running writes reach reload only
// - stopped writes load reload and counter
// - level select chooses pulse active level
// - polarity only matters for single edge
// - timer stopped after reset
// - start takes effect at next tick
// - stop takes effect at next tick
// - count source selectable among four
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "wot_cfg.svh"
module wot_timer (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire wot_pkg::wot_apb_req_s apbReq,
    output var  wot_pkg::wot_apb_rsp_s apbRsp,
    input  wire logic                  extTriggerPin,
    input  wire logic                  neighbourUnderflow,
    output var  logic                  pulseOutPin,
    output var  logic                  timerIrq,
    output var  logic                  extIrq
);
    import wot_pkg::*;

    wot_state_s st_ff;
    wot_state_s nxt_st;
    logic       tick;
    logic       trig;
    logic [3:0] dec;
    logic       setup;
    logic       wrEn;
    logic       stop;
    logic       uflow;
    logic [7:0] wData;

    // bit 3 flags a mapped word, bits 2:0 give its index
    function automatic logic [3:0] decodeAddr(input logic [`WOT_ADDR_W-1:0] a);
        case (a)
            `WOT_OFF_MODE:   decodeAddr = {1'b1, `WOT_IDX_MODE};
            `WOT_OFF_OUTCTL: decodeAddr = {1'b1, `WOT_IDX_OUTCTL};
            `WOT_OFF_TRIG:   decodeAddr = {1'b1, `WOT_IDX_TRIG};
            `WOT_OFF_SRC:    decodeAddr = {1'b1, `WOT_IDX_SRC};
            `WOT_OFF_PRESC:  decodeAddr = {1'b1, `WOT_IDX_PRESC};
            `WOT_OFF_PRIM:   decodeAddr = {1'b1, `WOT_IDX_PRIM};
            `WOT_OFF_SEC:    decodeAddr = {1'b1, `WOT_IDX_SEC};
            `WOT_OFF_STATUS: decodeAddr = {1'b1, `WOT_IDX_STATUS};
            default:         decodeAddr = 4'h0;
        endcase
    endfunction

    wot_count_source u_src (
        .clk                (clk),
        .rst                (rst),
        .srcSel             (st_ff.srcSel),
        .neighbourUnderflow (neighbourUnderflow),
        .tick               (tick)
    );

    wot_pin_sync u_pin (
        .clk      (clk),
        .rst      (rst),
        .pinIn    (extTriggerPin),
        .polarity (st_ff.trigPol),
        .bothEdge (st_ff.bothEdge),
        .edgeSeen (trig)
    );

    assign dec   = decodeAddr(apbReq.paddr);
    assign setup = apbReq.psel && !apbReq.penable;
    assign wrEn  = apbReq.psel && apbReq.penable && apbReq.pwrite
                   && st_ff.rsp.pready && dec[3];
    assign wData = apbReq.pwdata[7:0];
    assign uflow = tick && (st_ff.preCnt == '0) && (st_ff.tmrCnt == '0);

    always_comb begin
        nxt_st = st_ff;
        stop = 1'b0;
        nxt_st.timerIrq = 1'b0;
        nxt_st.extIrq = 1'b0;
        nxt_st.rsp = '0;
        // zero-wait slave: answer is registered in the setup cycle
        if (setup) begin
            nxt_st.rsp.pready = 1'b1;
            nxt_st.rsp.pslverr = !dec[3];
            unique case (dec[2:0])
                `WOT_IDX_MODE:   nxt_st.rsp.prdata = {26'h0, st_ff.opMode,
                                                      3'h0, st_ff.runAct};
                `WOT_IDX_OUTCTL: nxt_st.rsp.prdata = {30'h0, st_ff.levelSel, st_ff.oneShot};
                `WOT_IDX_TRIG:   nxt_st.rsp.prdata = {28'h0, st_ff.bothEdge, st_ff.extInEn,
                                                      st_ff.trigPol, st_ff.pinTrigEn};
                `WOT_IDX_SRC:    nxt_st.rsp.prdata = {30'h0, st_ff.srcSel};
                `WOT_IDX_PRESC:  nxt_st.rsp.prdata = {24'h0, st_ff.preCnt};
                `WOT_IDX_PRIM:   nxt_st.rsp.prdata = {24'h0, st_ff.tmrCnt};
                `WOT_IDX_SEC:    nxt_st.rsp.prdata = {24'h0, st_ff.secStage};
                `WOT_IDX_STATUS: nxt_st.rsp.prdata = {28'h0, st_ff.phase,
                                                      st_ff.pulseOut, st_ff.runReq};
            endcase
            if (!dec[3]) begin
                nxt_st.rsp.prdata = '0;
            end
        end
        if (wrEn) begin
            unique case (dec[2:0])
                `WOT_IDX_MODE: begin
                    nxt_st.runReq = apbReq.pwdata[`WOT_MODE_RUN];
                    nxt_st.opMode = apbReq.pwdata[`WOT_MODE_OPM_HI:`WOT_MODE_OPM_LO];
                end
                `WOT_IDX_OUTCTL: begin
                    nxt_st.oneShot = apbReq.pwdata[`WOT_OUT_ONESHOT];
                    nxt_st.levelSel = apbReq.pwdata[`WOT_OUT_LEVEL];
                end
                `WOT_IDX_TRIG: begin
                    nxt_st.pinTrigEn = apbReq.pwdata[`WOT_TRIG_PINEN];
                    nxt_st.trigPol = apbReq.pwdata[`WOT_TRIG_POL];
                    nxt_st.extInEn = apbReq.pwdata[`WOT_TRIG_EXTEN];
                    nxt_st.bothEdge = apbReq.pwdata[`WOT_TRIG_BOTH];
                end
                `WOT_IDX_SRC: begin
                    nxt_st.srcSel = apbReq.pwdata[1:0];
                end
                `WOT_IDX_PRESC: begin
                    nxt_st.preRel = wData;
                    if (!st_ff.runAct) begin
                        nxt_st.preCnt = wData;
                    end
                end
                `WOT_IDX_PRIM: begin
                    // primary write commits the staged secondary value
                    nxt_st.primRel = wData;
                    nxt_st.secRel = st_ff.secStage;
                    if (!st_ff.runAct) begin
                        nxt_st.tmrCnt = wData;
                    end
                end
                `WOT_IDX_SEC: begin
                    nxt_st.secStage = wData;
                    if (!st_ff.runAct) begin
                        nxt_st.secRel = wData;
                    end
                end
                `WOT_IDX_STATUS: begin
                end
            endcase
        end
        // pin events always raise the pin interrupt when the input is enabled
        if (trig && st_ff.extInEn) begin
            nxt_st.extIrq = 1'b1;
            if (st_ff.pinTrigEn && st_ff.runAct && st_ff.phase == WOT_PH_IDLE) begin
                nxt_st.oneShot = 1'b1;
            end
        end
        if (tick && st_ff.runReq != st_ff.runAct) begin
            nxt_st.runAct = st_ff.runReq;
            stop = !st_ff.runReq;
        end else if (tick && st_ff.runAct) begin
            unique case (st_ff.phase)
                WOT_PH_IDLE: begin
                end
                WOT_PH_WAIT, WOT_PH_PULSE: begin
                    if (st_ff.preCnt != '0) begin
                        nxt_st.preCnt = st_ff.preCnt - 1'b1;
                    end else begin
                        nxt_st.preCnt = st_ff.preRel;
                        if (st_ff.tmrCnt != '0) begin
                            nxt_st.tmrCnt = st_ff.tmrCnt - 1'b1;
                        end else if (st_ff.phase == WOT_PH_WAIT) begin
                            nxt_st.tmrCnt = st_ff.secRel;
                            nxt_st.phase = WOT_PH_PULSE;
                        end else begin
                            nxt_st.tmrCnt = st_ff.primRel;
                            nxt_st.phase = WOT_PH_IDLE;
                            nxt_st.oneShot = 1'b0;
                            nxt_st.timerIrq = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_st.phase = WOT_PH_IDLE;
                end
            endcase
        end
        if (st_ff.phase != WOT_PH_IDLE && !nxt_st.oneShot && !nxt_st.timerIrq) begin
            stop = 1'b1;
        end
        if (stop) begin
            nxt_st.phase = WOT_PH_IDLE;
            nxt_st.oneShot = 1'b0;
            nxt_st.tmrCnt = nxt_st.primRel;
            nxt_st.preCnt = nxt_st.preRel;
        end else if (st_ff.phase == WOT_PH_IDLE && st_ff.runAct && nxt_st.runAct
                     && nxt_st.oneShot) begin
            nxt_st.phase = WOT_PH_WAIT;
            nxt_st.tmrCnt = nxt_st.primRel;
            nxt_st.preCnt = nxt_st.preRel;
        end
        if (nxt_st.phase == WOT_PH_PULSE) begin
            nxt_st.pulseOut = nxt_st.levelSel;
        end else begin
            nxt_st.pulseOut = !nxt_st.levelSel;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.opMode <= `WOT_RST_OPMODE;
            st_ff.preRel <= `WOT_RST_RELOAD;
            st_ff.primRel <= `WOT_RST_RELOAD;
            st_ff.secRel <= `WOT_RST_RELOAD;
            st_ff.secStage <= `WOT_RST_RELOAD;
            st_ff.preCnt <= `WOT_RST_RELOAD;
            st_ff.tmrCnt <= `WOT_RST_RELOAD;
            st_ff.pulseOut <= `WOT_RST_PULSE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign apbRsp      = st_ff.rsp;
    assign pulseOutPin = st_ff.pulseOut;
    assign timerIrq    = st_ff.timerIrq;
    assign extIrq      = st_ff.extIrq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_WAIT_TO_PULSE: assert property (
        st_ff.phase == WOT_PH_WAIT && st_ff.runAct && st_ff.runReq && uflow
        && st_ff.oneShot && !wrEn
        |=> st_ff.phase == WOT_PH_PULSE && st_ff.tmrCnt == $past(st_ff.secRel)
            && pulseOutPin == st_ff.levelSel)
        else $error("wait underflow did not enter pulse phase");

    AST_PULSE_END: assert property (
        st_ff.phase == WOT_PH_PULSE && st_ff.runAct && st_ff.runReq && uflow
        && st_ff.oneShot && !wrEn
        |=> st_ff.phase == WOT_PH_IDLE && !st_ff.oneShot
            && st_ff.tmrCnt == $past(st_ff.primRel) && timerIrq)
        else $error("pulse underflow did not end the one-shot");

    AST_STOP_RELOAD: assert property (
        st_ff.phase != WOT_PH_IDLE && tick && st_ff.runAct && !st_ff.runReq && !wrEn
        |=> st_ff.phase == WOT_PH_IDLE && st_ff.tmrCnt == $past(st_ff.primRel)
            && st_ff.preCnt == $past(st_ff.preRel))
        else $error("stop did not reload the counters");

    AST_BUSY_TRIGGER: assert property (
        st_ff.phase == WOT_PH_WAIT && trig && st_ff.extInEn && st_ff.oneShot && !uflow
        && st_ff.runAct && st_ff.runReq && !wrEn
        |=> extIrq && st_ff.phase == WOT_PH_WAIT
            && st_ff.tmrCnt <= $past(st_ff.tmrCnt))
        else $error("busy trigger disturbed the count");

    AST_IRQ_AT_END: assert property (
        timerIrq |-> st_ff.phase == WOT_PH_IDLE && pulseOutPin != st_ff.levelSel
                     && $past(st_ff.phase) == WOT_PH_PULSE)
        else $error("timer interrupt not aligned with end of pulse");

    AST_RUN_WRITE_RELOAD_ONLY: assert property (
        wrEn && dec[2:0] == `WOT_IDX_PRIM && st_ff.runAct && st_ff.runReq && !trig
        && ((st_ff.phase == WOT_PH_IDLE && !st_ff.oneShot)
            || (st_ff.phase == WOT_PH_WAIT && !tick))
        |=> st_ff.tmrCnt == $past(st_ff.tmrCnt) && st_ff.primRel == $past(wData))
        else $error("running write reached the counter");

    AST_STOPPED_WRITE_BOTH: assert property (
        wrEn && dec[2:0] == `WOT_IDX_PRIM && !st_ff.runAct
        |=> st_ff.tmrCnt == $past(wData) && st_ff.primRel == $past(wData))
        else $error("stopped write did not load the counter");

    AST_PIN_LEVEL: assert property (
        st_ff.phase != WOT_PH_PULSE |-> pulseOutPin == !st_ff.levelSel)
        else $error("pulse pin active outside pulse phase");

    AST_START_LATENCY: assert property (
        !st_ff.runAct && st_ff.runReq
        |=> st_ff.runAct == $past(tick))
        else $error("run bit did not follow the next tick");

    AST_STOP_LATENCY: assert property (
        st_ff.runAct && !st_ff.runReq
        |=> st_ff.runAct == !$past(tick))
        else $error("run bit did not clear at the next tick");

    AST_APB_ANSWER: assert property (
        setup |=> apbRsp.pready ##1 !apbRsp.pready)
        else $error("apb answer not one cycle after setup");

    COV_PULSE: cover property (st_ff.phase == WOT_PH_WAIT ##1 st_ff.phase == WOT_PH_PULSE);
    COV_IRQ: cover property (timerIrq);
    COV_PIN_START: cover property (trig && st_ff.pinTrigEn ##1 st_ff.phase == WOT_PH_WAIT);
    COV_RUN_STOP: cover property (st_ff.phase == WOT_PH_PULSE ##1 !st_ff.runAct);
endmodule
`default_nettype wire

// >>> dv/wait_oneshot_pulse_timer_bench.sv
// self-checking bench of the wait one-shot pulse timer
`timescale 1ns/10ps
`default_nettype none
`include "wot_cfg.svh"
module wait_oneshot_pulse_timer_bench;
    import wot_pkg::*;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic        err;
    } wot_row_s;
    logic         clk;
    logic         rst;
    wot_apb_req_s apbReq;
    wot_apb_rsp_s apbRsp;
    logic         trigPin;
    logic         fire;
    logic         neighbourUnderflow;
    logic         pulseOutPin;
    logic         timerIrq;
    logic         extIrq;
    logic [31:0]  rd;
    logic         err;
    int           badCount;
    int           samplesChecked;
    int           extSeen;
    wot_row_s     rows [8];

    wot_timer wot_timer_inst (
        .clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
        .extTriggerPin(trigPin), .neighbourUnderflow(neighbourUnderflow),
        .pulseOutPin(pulseOutPin), .timerIrq(timerIrq), .extIrq(extIrq)
    );
    wot_trig_src wot_trig_src_inst (.clk(clk), .rst(rst), .fire(fire), .pin(trigPin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (extIrq === 1'b1) begin
            extSeen++;
        end
    end

    task automatic printVerdict();
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic waitPin(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pulseOutPin !== lvl && n < 300);
        chk(pulseOutPin, lvl);
    endtask

    // read run bit until it shows the wanted value, touching nothing else
    task automatic waitRun(input logic v);
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, `WOT_OFF_MODE, 32'h0);
            if (rd[0] === v) begin
                break;
            end
        end
        chk(rd[0], v);
    endtask

    task automatic pulseFire();
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    initial begin
        int n;
        rst = 1'b1;
        apbReq = '0;
        fire = 1'b0;
        neighbourUnderflow = 1'b0;
        badCount = 0;
        samplesChecked = 0;
        extSeen = 0;
        rows = '{'{`WOT_OFF_MODE, 32'h0000_0030, 1'b0}, '{`WOT_OFF_OUTCTL, 32'h0, 1'b0},
                 '{`WOT_OFF_PRESC, 32'h0000_00FF, 1'b0}, '{`WOT_OFF_PRIM, 32'h0000_00FF, 1'b0},
                 '{`WOT_OFF_SEC, 32'h0000_00FF, 1'b0}, '{`WOT_OFF_STATUS, 32'h0000_0002, 1'b0},
                 '{12'h020, 32'h0, 1'b1}, '{12'h006, 32'h0, 1'b1}};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk(pulseOutPin, 1'b1);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].addr, 32'h0);
            chk(rd, rows[i].data);
            chk(err, rows[i].err);
        end
        apb(1'b1, `WOT_OFF_SRC, 32'h0000_0003);
        apb(1'b1, `WOT_OFF_PRESC, 32'h0000_0001);
        apb(1'b1, `WOT_OFF_PRIM, 32'h0000_0002);
        apb(1'b1, `WOT_OFF_SEC, 32'h0000_0001);
        apb(1'b1, `WOT_OFF_OUTCTL, 32'h0000_0002);
        apb(1'b0, `WOT_OFF_PRIM, 32'h0);
        chk(rd, 32'h0000_0002);
        chk(pulseOutPin, 1'b0);
        apb(1'b1, `WOT_OFF_MODE, 32'h0000_0031);
        // neighbour source held quiet: the start must not be seen yet
        repeat (3) apb(1'b0, `WOT_OFF_MODE, 32'h0);
        chk(rd[0], 1'b0);
        @(posedge clk);
        neighbourUnderflow <= 1'b1;
        @(posedge clk);
        neighbourUnderflow <= 1'b0;
        waitRun(1'b1);
        apb(1'b1, `WOT_OFF_SRC, 32'h0);
        apb(1'b1, `WOT_OFF_OUTCTL, 32'h0000_0003);
        waitPin(1'b1, n);
        chk(n, 32'd6);
        waitPin(1'b0, n);
        chk(n, 32'd4);
        chk(timerIrq, 1'b1);
        apb(1'b0, `WOT_OFF_OUTCTL, 32'h0);
        chk(rd, 32'h0000_0002);
        apb(1'b1, `WOT_OFF_PRIM, 32'h0);
        apb(1'b0, `WOT_OFF_PRIM, 32'h0);
        chk(rd, 32'h0000_0002);
        apb(1'b1, `WOT_OFF_OUTCTL, 32'h0000_0003);
        waitPin(1'b1, n);
        chk(n, 32'd2);
        waitPin(1'b0, n);
        apb(1'b1, `WOT_OFF_PRIM, 32'h0000_0040);
        apb(1'b1, `WOT_OFF_OUTCTL, 32'h0000_0003);
        repeat (10) @(posedge clk);
        chk(pulseOutPin, 1'b0);
        apb(1'b1, `WOT_OFF_MODE, 32'h0000_0030);
        waitRun(1'b0);
        apb(1'b0, `WOT_OFF_PRIM, 32'h0);
        chk(rd, 32'h0000_0040);
        apb(1'b0, `WOT_OFF_OUTCTL, 32'h0);
        chk(rd, 32'h0000_0002);
        apb(1'b1, `WOT_OFF_PRIM, 32'h0000_0004);
        apb(1'b1, `WOT_OFF_TRIG, 32'h0000_0004);
        apb(1'b1, `WOT_OFF_MODE, 32'h0000_0031);
        waitRun(1'b1);
        pulseFire();
        repeat (10) @(posedge clk);
        chk(extSeen, 32'd1);
        chk(pulseOutPin, 1'b0);
        apb(1'b1, `WOT_OFF_TRIG, 32'h0000_0005);
        pulseFire();
        repeat (6) @(posedge clk);
        pulseFire();
        waitPin(1'b1, n);
        waitPin(1'b0, n);
        chk(n, 32'd4);
        repeat (20) @(posedge clk);
        chk(extSeen, 32'd3);
        chk(pulseOutPin, 1'b0);
        apb(1'b1, `WOT_OFF_MODE, 32'h0000_0030);
        waitRun(1'b0);
        apb(1'b1, `WOT_OFF_TRIG, 32'h0);
        apb(1'b1, `WOT_OFF_TRIG, 32'h0000_000E);
        pulseFire();
        repeat (15) @(posedge clk);
        chk(extSeen, 32'd5);
        printVerdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        printVerdict();
    end
endmodule
`default_nettype wire

// >>> dv/wot_trig_src.sv
// trigger source model driving the external trigger pin
`timescale 1ns/10ps
`default_nettype none
module wot_trig_src (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic fire,
    output var  logic pin
);
    logic [2:0] hold_ff;
    // rising active edge, held long enough to pass the two-flop synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_ff <= 3'h0;
        end else if (fire) begin
            hold_ff <= 3'h4;
        end else if (hold_ff != 3'h0) begin
            hold_ff <= hold_ff - 3'h1;
        end
    end
    assign pin = (hold_ff != 3'h0);
endmodule
`default_nettype wire
